//--- hdl/dps_supervisor.sv
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "dps_consts.svh"

module dps_supervisor #(
  parameter int unsigned NUM_DI    = 62,
  parameter int unsigned MS_CYCLES = `DPS_MS_CYCLES
) (
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  // AXI4-Lite write
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [7:0]        s_axi_awaddr_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  output logic [1:0]             s_axi_bresp_o,
  // AXI4-Lite read
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  input  wire logic [7:0]        s_axi_araddr_i,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  // Measurements
  input  wire logic [15:0]       thermistor_sense_input_i,
  input  wire logic [15:0]       speed_i,
  input  wire logic [7:0]        dc_link_pct_i,
  input  wire logic [NUM_DI-1:0] di_i,
  // Protection outputs
  output logic                   thermistor_overtemp_alarm_o,
  output logic                   thermistor_overtemp_fault_o,
  output logic                   overspeed_fault_o,
  output logic                   undervoltage_fault_o,
  output logic                   external_alarm_event_o,
  output logic                   external_fault_event_o,
  output logic                   ride_through_o,
  output logic                   general_disable_o,
  output logic                   modulation_disable_o
);

  // ==========================================
  // Elaboration checks
  if (NUM_DI < 1 || NUM_DI > 62) begin : g_bad_di
    $error("NUM_DI must be 1 to 62");
  end
  if (MS_CYCLES < 2 || MS_CYCLES > 65535) begin : g_bad_ms
    $error("MS_CYCLES must be 2 to 65535");
  end

  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  localparam dps_pkg::dps_state_s ST_RST = '{
    cfg:     `DPS_CFG_RST,
    uv_lvl:  `DPS_UVLVL_RST,
    ovs_mar: `DPS_OVSMAR_RST,
    max_spd: `DPS_MAXSPD_RST,
    ar_time: `DPS_ARTIME_RST,
    alm_sel: `DPS_SEL_RST,
    flt_sel: `DPS_SEL_RST,
    default: '0
  };

  dps_pkg::dps_state_s st_r;
  dps_pkg::dps_state_s st_nxt;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================
  // Combinational helpers
  logic [NUM_DI:0] di_now;
  logic [NUM_DI:0] di_old;
  logic            alm_fall;
  logic            alm_rise;
  logic            flt_fall;
  logic            in_band;
  logic            alm_en;
  logic            flt_en;
  logic            over_spd;
  logic            uv_low;
  logic            wr_go;
  logic            man_rst;
  logic            auto_rst;
  logic            ar_en;
  logic [3:0]      flt_set;
  logic [3:0]      flt_clr;
  logic [31:0]     status_w;
  logic [31:0]     rd_w;
  logic            rd_ok;
  logic [31:0]     wr_w;
  logic [31:0]     spd_x100;
  logic [31:0]     lim_x100;

  // Slot 0 idles high and selector 0 means unused
  assign di_now = {st_r.sync2[NUM_DI-1:0], 1'b1};
  assign di_old = {st_r.prev[NUM_DI-1:0], 1'b1};

  // Selectors past the fitted inputs stay idle
  always_comb begin
    alm_fall = 1'b0;
    alm_rise = 1'b0;
    flt_fall = 1'b0;
    if (32'(st_r.alm_sel) <= NUM_DI && st_r.alm_sel != 6'h00) begin
      alm_fall = di_old[st_r.alm_sel] & ~di_now[st_r.alm_sel]; // RULE_18
      alm_rise = ~di_old[st_r.alm_sel] & di_now[st_r.alm_sel]; // RULE_18
    end
    if (32'(st_r.flt_sel) <= NUM_DI && st_r.flt_sel != 6'h00) begin
      flt_fall = di_old[st_r.flt_sel] & ~di_now[st_r.flt_sel]; // RULE_20
    end
  end

  assign in_band = (thermistor_sense_input_i > `DPS_REL_LO_MV) &&
                   (thermistor_sense_input_i < `DPS_REL_HI_MV); // RULE_04
  assign alm_en  = (st_r.cfg == 2'h0) || (st_r.cfg == 2'h2); // RULE_01
  assign flt_en  = (st_r.cfg == 2'h0) || (st_r.cfg == 2'h1); // RULE_01

  // Cross-multiplied to avoid a divider
  assign spd_x100 = 32'(speed_i) * 32'h64;
  assign lim_x100 = 32'(st_r.max_spd) * (32'h64 + 32'(st_r.ovs_mar));
  assign over_spd = (st_r.ovs_mar < `DPS_OVS_OFF_PCT) && (spd_x100 > lim_x100); // RULE_12

  assign uv_low = dc_link_pct_i < {1'b0, st_r.uv_lvl}; // RULE_09

  // ==========================================
  // Register file
  assign wr_go = st_r.aw_ok && st_r.w_ok && !st_r.bvalid;
  assign wr_w  = st_r.wdata;
  assign man_rst = wr_go && st_r.awaddr == `DPS_OFS_CTRL && st_r.wstrb[0] &&
                   wr_w[`DPS_CTRL_RST_BIT];

  assign status_w = {23'h0, st_r.inhibit, st_r.rt_act, st_r.mod_dis, st_r.flt[3],
                     st_r.ext_alm, st_r.flt[2], st_r.flt[1], st_r.flt[0], st_r.th_alm};

  always_comb begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr_i)
      `DPS_OFS_CTRL:   rd_w = {29'h0, st_r.rt_en, st_r.cfg};
      `DPS_OFS_UVLVL:  rd_w = {25'h0, st_r.uv_lvl};
      `DPS_OFS_OVSMAR: rd_w = {25'h0, st_r.ovs_mar};
      `DPS_OFS_MAXSPD: rd_w = {16'h0, st_r.max_spd};
      `DPS_OFS_ARTIME: rd_w = {20'h0, st_r.ar_time};
      `DPS_OFS_EXTSEL: rd_w = {18'h0, st_r.flt_sel, 2'h0, st_r.alm_sel};
      `DPS_OFS_STATUS: rd_w = status_w;
      default: begin
        rd_w  = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign s_axi_awready_o = !st_r.aw_ok;
  assign s_axi_wready_o  = !st_r.w_ok;
  assign s_axi_arready_o = !st_r.rvalid;
  assign s_axi_bvalid_o  = st_r.bvalid;
  assign s_axi_bresp_o   = st_r.bresp;
  assign s_axi_rvalid_o  = st_r.rvalid;
  assign s_axi_rdata_o   = st_r.rdata;
  assign s_axi_rresp_o   = st_r.rresp;

  // ==========================================
  // Next state
  assign ar_en    = (st_r.ar_time > `DPS_AR_MIN_S) && !st_r.inhibit; // RULE_14
  assign auto_rst = ar_en && st_r.sec_tick && (|st_r.flt) &&
                    (st_r.ar_sec + 12'h001 >= st_r.ar_time); // RULE_13

  always_comb begin
    logic [31:0] m;
    m = 32'h0;
    st_nxt = st_r;

    // AXI channels
    if (s_axi_awvalid_i && !st_r.aw_ok) begin
      st_nxt.aw_ok  = 1'b1;
      st_nxt.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !st_r.w_ok) begin
      st_nxt.w_ok  = 1'b1;
      st_nxt.wdata = s_axi_wdata_i;
      st_nxt.wstrb = s_axi_wstrb_i;
    end
    if (wr_go) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = 2'h0;
      unique case (st_r.awaddr)
        `DPS_OFS_CTRL: begin
          m = merge({29'h0, st_r.rt_en, st_r.cfg}, wr_w, st_r.wstrb);
          st_nxt.cfg   = m[`DPS_CTRL_CFG_LSB +: 2]; // RULE_01
          st_nxt.rt_en = m[`DPS_CTRL_RT_BIT];
        end
        `DPS_OFS_UVLVL: begin
          m = merge({25'h0, st_r.uv_lvl}, wr_w, st_r.wstrb);
          st_nxt.uv_lvl = m[6:0];
        end
        `DPS_OFS_OVSMAR: begin
          m = merge({25'h0, st_r.ovs_mar}, wr_w, st_r.wstrb);
          st_nxt.ovs_mar = m[6:0];
        end
        `DPS_OFS_MAXSPD: begin
          m = merge({16'h0, st_r.max_spd}, wr_w, st_r.wstrb);
          st_nxt.max_spd = m[15:0];
        end
        `DPS_OFS_ARTIME: begin
          m = merge({20'h0, st_r.ar_time}, wr_w, st_r.wstrb);
          st_nxt.ar_time = m[11:0];
        end
        `DPS_OFS_EXTSEL: begin
          m = merge({18'h0, st_r.flt_sel, 2'h0, st_r.alm_sel}, wr_w, st_r.wstrb);
          st_nxt.alm_sel = m[`DPS_SEL_ALM_LSB +: 6]; // RULE_17
          st_nxt.flt_sel = m[`DPS_SEL_FLT_LSB +: 6]; // RULE_17
        end
        `DPS_OFS_STATUS: st_nxt.bresp = 2'h0;
        default:         st_nxt.bresp = 2'h2;
      endcase
    end
    if (st_r.bvalid && s_axi_bready_i) begin
      st_nxt.bvalid = 1'b0;
      st_nxt.aw_ok  = 1'b0;
      st_nxt.w_ok   = 1'b0;
    end
    if (s_axi_arvalid_i && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_w;
      st_nxt.rresp  = rd_ok ? 2'h0 : 2'h2;
    end else if (st_r.rvalid && s_axi_rready_i) begin
      st_nxt.rvalid = 1'b0;
    end

    // Input synchronisers
    st_nxt.sync1 = 62'(di_i); // RULE_22
    st_nxt.sync2 = st_r.sync1; // RULE_22
    st_nxt.prev  = st_r.sync2;

    // Time base
    st_nxt.ms_tick  = (st_r.presc == MS_LAST);
    st_nxt.presc    = st_nxt.ms_tick ? 16'h0 : st_r.presc + 16'h1;
    st_nxt.sec_tick = 1'b0;
    if (st_r.ms_tick) begin
      st_nxt.sec_ms = (st_r.sec_ms == `DPS_MS_PER_S) ? 10'h0 : st_r.sec_ms + 10'h1;
      st_nxt.sec_tick = (st_r.sec_ms == `DPS_MS_PER_S);
    end

    // Thermistor alarm; clearing only inside the release band, or at once when the config turns the alarm off
    if (!alm_en) begin
      st_nxt.th_alm = 1'b0;
    end else if (thermistor_sense_input_i > `DPS_ALM_MV) begin
      st_nxt.th_alm = 1'b1; // RULE_02
    end else if (in_band) begin
      st_nxt.th_alm = 1'b0; // RULE_04
    end

    // External alarm is flag only, never reaches modulation
    if (alm_fall) begin
      st_nxt.ext_alm = 1'b1; // RULE_18 RULE_19
    end else if (alm_rise) begin
      st_nxt.ext_alm = 1'b0; // RULE_18
    end

    // Overspeed persistence in ms ticks
    if (!over_spd) begin
      st_nxt.ovs_cnt = 5'h0;
    end else if (st_r.ms_tick && st_r.ovs_cnt != `DPS_OVS_MS) begin
      st_nxt.ovs_cnt = st_r.ovs_cnt + 5'h1;
    end

    // Ride-through replaces the undervoltage trip
    st_nxt.rt_act = st_r.rt_en && uv_low; // RULE_10

    // Fault sources
    flt_set[dps_pkg::DPS_F_THERM] = flt_en &&
        ((thermistor_sense_input_i > `DPS_FLT_MV) ||
         (thermistor_sense_input_i < `DPS_MINR_MV)); // RULE_03 RULE_06
    flt_set[dps_pkg::DPS_F_OVS] = over_spd && st_r.ms_tick &&
                                  st_r.ovs_cnt == `DPS_OVS_MS; // RULE_11
    flt_set[dps_pkg::DPS_F_UV]  = !st_r.rt_en && uv_low; // RULE_09
    flt_set[dps_pkg::DPS_F_EXT] = flt_fall; // RULE_20

    // Thermistor fault stays latched outside the band unless the config turns the fault off
    flt_clr = {4{man_rst || auto_rst}};
    flt_clr[dps_pkg::DPS_F_THERM] = flt_clr[dps_pkg::DPS_F_THERM] &&
                                    (in_band || !flt_en); // RULE_05 RULE_07
    // Set wins over clear
    st_nxt.flt = (st_r.flt & ~flt_clr) | flt_set; // RULE_21
    st_nxt.mod_dis = |st_nxt.flt; // RULE_21 RULE_11

    // Auto-reset timer in seconds
    if (!(|st_r.flt) || !ar_en || auto_rst) begin
      st_nxt.ar_sec = 12'h0;
    end else if (st_r.sec_tick) begin
      st_nxt.ar_sec = st_r.ar_sec + 12'h1; // RULE_13
    end

    // Recurrence window after an automatic reset
    if (auto_rst) begin
      st_nxt.win_act  = 1'b1;
      st_nxt.win_sec  = 5'h0;
      st_nxt.last_set = st_r.flt;
    end else if (st_r.win_act && st_r.sec_tick) begin
      st_nxt.win_sec = st_r.win_sec + 5'h1;
      st_nxt.win_act = (st_r.win_sec + 5'h1 < `DPS_RECUR_S); // RULE_15
    end

    // Manual reset first, so a repeat in the same cycle still counts
    if (man_rst) begin
      st_nxt.rec     = '0;
      st_nxt.win_act = 1'b0;
      st_nxt.inhibit = 1'b0;
    end
    for (int k = 0; k < 4; k++) begin
      if (flt_set[k] && !st_r.flt[k]) begin
        if (st_r.win_act && st_r.last_set[k]) begin
          if (st_r.rec[k] != `DPS_RECUR_MAX) begin
            st_nxt.rec[k] = st_r.rec[k] + 2'h1; // RULE_15
          end
        end else begin
          st_nxt.rec[k] = 2'h0;
        end
      end
    end
    // Inhibit holds until a manual reset
    for (int k = 0; k < 4; k++) begin
      if (st_nxt.rec[k] == `DPS_RECUR_MAX) begin
        st_nxt.inhibit = 1'b1; // RULE_16
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // Outputs
  assign thermistor_overtemp_alarm_o = st_r.th_alm;
  assign thermistor_overtemp_fault_o = st_r.flt[dps_pkg::DPS_F_THERM];
  assign overspeed_fault_o           = st_r.flt[dps_pkg::DPS_F_OVS];
  assign undervoltage_fault_o        = st_r.flt[dps_pkg::DPS_F_UV];
  assign external_alarm_event_o      = st_r.ext_alm;
  assign external_fault_event_o      = st_r.flt[dps_pkg::DPS_F_EXT];
  assign ride_through_o              = st_r.rt_act;
  assign general_disable_o           = st_r.inhibit && (|st_r.flt);
  assign modulation_disable_o        = st_r.mod_dis;

  // ==========================================
  // Assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_ovs_trip;
    over_spd && st_r.ms_tick && st_r.ovs_cnt == `DPS_OVS_MS;
  endsequence
  sequence s_fall_sel;
    flt_fall;
  endsequence

  cfg_reset_a: assert property (
    $fell(sys_rst_i) |-> st_r.cfg == `DPS_CFG_RST) else $error("cfg reset"); // RULE_01
  alarm_set_a: assert property ( // RULE_02
    alm_en && thermistor_sense_input_i > `DPS_ALM_MV |=> st_r.th_alm)
    else $error("alarm not set");
  therm_trip_a: assert property ( // RULE_03 RULE_06
    flt_en && (thermistor_sense_input_i > `DPS_FLT_MV ||
     thermistor_sense_input_i < `DPS_MINR_MV) |=> ##1 modulation_disable_o)
    else $error("therm trip missing");
  alarm_hold_a: assert property ( // RULE_04
    st_r.th_alm && alm_en && !in_band |=> st_r.th_alm)
    else $error("alarm dropped outside band");
  therm_latch_a: assert property ( // RULE_05
    st_r.flt[0] && !in_band && flt_en |=> st_r.flt[0])
    else $error("therm fault cleared outside band");
  uv_trip_a: assert property (
    !st_r.rt_en && uv_low |=> undervoltage_fault_o) else $error("uv missed"); // RULE_09
  ovs_trip_a: assert property ( // RULE_11
    s_ovs_trip |=> overspeed_fault_o ##1 modulation_disable_o)
    else $error("overspeed trip");
  ovs_off_a: assert property ( // RULE_12
    st_r.ovs_mar >= `DPS_OVS_OFF_PCT |-> st_r.ovs_cnt == 5'h0)
    else $error("overspeed not disabled");
  no_auto_a: assert property (
    st_r.ar_time <= `DPS_AR_MIN_S |-> !auto_rst) else $error("auto reset"); // RULE_14
  inhibit_a: assert property ( // RULE_16
    st_r.inhibit && !man_rst |-> !auto_rst ##1 st_r.inhibit)
    else $error("inhibit lost");
  ext_flt_a: assert property ( // RULE_20
    s_fall_sel |=> external_fault_event_o ##1 modulation_disable_o)
    else $error("ext fault");
  ext_alm_a: assert property ( // RULE_18 RULE_19
    alm_fall && !(|st_r.flt) |=> external_alarm_event_o && !st_r.mod_dis)
    else $error("ext alarm");
  mod_dis_a: assert property (
    |st_r.flt |-> st_r.mod_dis) else $error("modulation not held off"); // RULE_21

endmodule

//--- shared/dps_consts.svh
`ifndef DPS_CONSTS_SVH
`define DPS_CONSTS_SVH
// Function
// [RULE_01] Config 0 both, 1 fault, 2 alarm, 3 off
// [RULE_02] Alarm when sense above 7.0 V
// [RULE_03] Fault when sense above 7.8 V
// [RULE_04] Alarm clears only within 0.3-3.2 V
// [RULE_05] Fault clearable only within 0.3-3.2 V
// [RULE_06] Fault when sense below 0.12 V
// [RULE_07] Fault holds until temperature released
// [RULE_08] Software sets analog pins to thermistor
// [RULE_09] Undervoltage fault below level, default 70
// [RULE_10] Ride-through uses undervoltage level
// [RULE_11] Overspeed over 20 ms trips, disables modulation
// [RULE_12] Margin 0-100, default 10, 100 disables
// [RULE_13] Auto-reset after programmed time, default 0
// [RULE_14] Time at most 2 means no auto-reset
// [RULE_15] Recurrent if repeats within 30 s
// [RULE_16] Three recurrences inhibit auto-reset
// [RULE_17] Input selectors 0-62, default 0
// [RULE_18] Alarm sets on fall, clears on rise
// [RULE_19] External alarm never stops motor
// [RULE_20] Fault on selected input falling edge
// [RULE_21] Any fault holds modulation disabled
// [RULE_22] Edges from synchronised input samples

// ==========================================
// Register byte offsets
`define DPS_OFS_CTRL     8'h00
`define DPS_OFS_UVLVL    8'h04
`define DPS_OFS_OVSMAR   8'h08
`define DPS_OFS_MAXSPD   8'h0C
`define DPS_OFS_ARTIME   8'h10
`define DPS_OFS_EXTSEL   8'h14
`define DPS_OFS_STATUS   8'h18
// CTRL fields
`define DPS_CTRL_CFG_LSB 0
`define DPS_CTRL_RT_BIT  2
`define DPS_CTRL_RST_BIT 3
// EXTSEL fields
`define DPS_SEL_ALM_LSB  0
`define DPS_SEL_FLT_LSB  8

// ==========================================
// Reset values
`define DPS_CFG_RST      2'h3
`define DPS_UVLVL_RST    7'h46
`define DPS_OVSMAR_RST   7'h0A
`define DPS_MAXSPD_RST   16'h0708
`define DPS_ARTIME_RST   12'h000
`define DPS_SEL_RST      6'h00

// ==========================================
// Levels in millivolts, percent and seconds
`define DPS_ALM_MV       16'h1B58
`define DPS_FLT_MV       16'h1E78
`define DPS_REL_LO_MV    16'h012C
`define DPS_REL_HI_MV    16'h0C80
`define DPS_MINR_MV      16'h0078
`define DPS_OVS_OFF_PCT  7'h64
`define DPS_AR_MIN_S     12'h002

// ==========================================
// Timing
`define DPS_CLK_MHZ      25
`define DPS_TICK_US      1000
`define DPS_MS_CYCLES    (`DPS_TICK_US * `DPS_CLK_MHZ)
`define DPS_OVS_MS       5'h14
`define DPS_MS_PER_S     10'h3E7
`define DPS_RECUR_S      5'h1E
`define DPS_RECUR_MAX    2'h3
`endif

//--- shared/dps_pkg.sv
package dps_pkg;

  // Fault slots
  typedef enum logic [1:0] {
    DPS_F_THERM,
    DPS_F_OVS,
    DPS_F_UV,
    DPS_F_EXT
  } dps_flt_e;

  typedef struct packed {
    logic            aw_ok;
    logic            w_ok;
    logic [7:0]      awaddr;
    logic [31:0]     wdata;
    logic [3:0]      wstrb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic [1:0]      cfg;
    logic            rt_en;
    logic [6:0]      uv_lvl;
    logic [6:0]      ovs_mar;
    logic [15:0]     max_spd;
    logic [11:0]     ar_time;
    logic [5:0]      alm_sel;
    logic [5:0]      flt_sel;
    logic [61:0]     sync1;
    logic [61:0]     sync2;
    logic [61:0]     prev;
    logic            th_alm;
    logic            ext_alm;
    logic            rt_act;
    logic [3:0]      flt;
    logic            mod_dis;
    logic [15:0]     presc;
    logic            ms_tick;
    logic [4:0]      ovs_cnt;
    logic [9:0]      sec_ms;
    logic            sec_tick;
    logic [11:0]     ar_sec;
    logic [4:0]      win_sec;
    logic            win_act;
    logic [3:0]      last_set;
    logic [3:0][1:0] rec;
    logic            inhibit;
  } dps_state_s;

endpackage

//--- bench/dps_front_model.sv
`timescale 1ns/100ps
module dps_front_model (
  // Clock
  input  wire logic   clk_sys_i,
  // Measurements and inputs
  output logic [15:0] sense_o  = 16'h03E8,
  output logic [15:0] speed_o  = 16'h03E8,
  output logic [7:0]  dc_pct_o = 8'h64,
  output logic [61:0] di_o     = {62{1'b1}}
);
  // ====================
  // Targets set by the bench
  // Analog pins stay in thermistor mode for the whole run
  logic [15:0] sense_set = 16'h03E8;
  logic [15:0] speed_set = 16'h03E8;
  logic [7:0]  dc_set    = 8'h64;
  logic [61:0] di_set    = {62{1'b1}};

  // ====================
  // Launch
  // Values move only on the edge, like a sampled converter
  always @(posedge clk_sys_i) begin
    sense_o  <= sense_set;
    speed_o  <= speed_set;
    dc_pct_o <= dc_set;
    di_o     <= di_set;
  end
endmodule

//--- bench/tb.sv
`timescale 1ns/100ps
`include "dps_consts.svh"
module tb;
  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        awvalid   = 1'b0;
  logic        wvalid    = 1'b0;
  logic        bready    = 1'b0;
  logic        arvalid   = 1'b0;
  logic        rready    = 1'b0;
  logic [7:0]  awaddr    = 8'h00;
  logic [7:0]  araddr    = 8'h00;
  logic [31:0] wdata     = 32'h0000_0000;
  logic [31:0] rdata, rd;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  logic [15:0] sense, speed;
  logic [7:0]  dc_pct;
  logic [61:0] di;
  logic        th_alm, th_flt, ovs_flt, uv_flt, ext_alm, ext_flt, rt, gdis, mdis;
  int          miscompares  = 0;
  int          total_checks = 0;
  int          cycles       = 0;

  dps_supervisor #(.MS_CYCLES(4)) DUT (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .thermistor_sense_input_i(sense), .speed_i(speed), .dc_link_pct_i(dc_pct), .di_i(di),
    .thermistor_overtemp_alarm_o(th_alm), .thermistor_overtemp_fault_o(th_flt),
    .overspeed_fault_o(ovs_flt), .undervoltage_fault_o(uv_flt),
    .external_alarm_event_o(ext_alm), .external_fault_event_o(ext_flt),
    .ride_through_o(rt), .general_disable_o(gdis), .modulation_disable_o(mdis));

  dps_front_model FM (
    .clk_sys_i(clk_sys_i), .sense_o(sense), .speed_o(speed), .dc_pct_o(dc_pct), .di_o(di));

  // ====================
  // Clock and watchdog
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // Run needs about 64k cycles, mostly the auto-reset waits
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles >= 90000) begin
      miscompares++;
      final_report;
    end
  end

  // ====================
  // Helpers
  task automatic chk(input logic got, input logic exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task automatic setv(input logic [15:0] v);
    FM.sense_set = v;
    cyc(3);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, done;
    done = 1'b0;
    @(posedge clk_sys_i);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    while (!done) begin
      @(negedge clk_sys_i);
      ah   = awvalid & awready;
      wh   = wvalid & wready;
      done = bvalid;
      rsp  = bresp;
      @(posedge clk_sys_i);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, done;
    done = 1'b0;
    @(posedge clk_sys_i);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    while (!done) begin
      @(negedge clk_sys_i);
      ah   = arvalid & arready;
      done = rvalid;
      d    = rdata;
      r    = rresp;
      @(posedge clk_sys_i);
      if (ah) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
  endtask

  // ====================
  // Scenarios
  task automatic t_reset;
    logic [31:0] exp [6];
    exp = '{32'h3, 32'h46, 32'h0A, 32'h708, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++) begin
      axi_rd(8'(4 * i), rd, rsp);
      chk(rd === exp[i], 1'b1, "reset value");
    end
    axi_rd(8'h1C, rd, rsp);
    chk(rsp === 2'h2, 1'b1, "unmapped read not refused");
    axi_wr(8'h1C, 32'h1);
    chk(rsp === 2'h2, 1'b1, "unmapped write not refused");
    $display("test reset done");
  endtask

  task automatic t_therm;
    logic [3:0] al, fl;
    al = 4'b0101;
    fl = 4'b0011;
    for (int c = 0; c < 4; c++) begin
      axi_wr(`DPS_OFS_CTRL, 32'(c));
      setv(16'h1EDC);
      chk(th_alm, al[c], "alarm per mode");
      chk(th_flt, fl[c], "fault per mode");
      chk(mdis, fl[c], "disable per mode");
      setv(16'h03E8);
      axi_wr(`DPS_OFS_CTRL, 32'(c) | 32'h8);
    end
    axi_wr(`DPS_OFS_CTRL, 32'h0);
    setv(16'h1B58);
    chk(th_alm, 1'b0, "alarm at 7000");
    setv(16'h1B59);
    chk(th_alm, 1'b1, "alarm at 7001");
    setv(16'h1E78);
    chk(th_flt, 1'b0, "fault at 7800");
    setv(16'h1E79);
    chk(th_flt, 1'b1, "fault at 7801");
    setv(16'h1388);
    axi_wr(`DPS_OFS_CTRL, 32'h8);
    cyc(2);
    chk(th_alm, 1'b1, "alarm left band");
    chk(th_flt, 1'b1, "fault reset out of band");
    setv(16'h03E8);
    chk(th_alm, 1'b0, "alarm in band");
    chk(th_flt, 1'b1, "fault not latched");
    axi_wr(`DPS_OFS_CTRL, 32'h8);
    cyc(2);
    chk(th_flt, 1'b0, "fault reset in band");
    chk(mdis, 1'b0, "disable after reset");
    setv(16'h0078);
    chk(th_flt, 1'b0, "fault at 120");
    setv(16'h0077);
    chk(th_flt, 1'b1, "fault at 119");
    setv(16'h03E8);
    axi_wr(`DPS_OFS_CTRL, 32'hB);
    $display("test thermistor done");
  endtask

  task automatic t_uv;
    FM.dc_set = 8'h45;
    cyc(3);
    chk(uv_flt, 1'b1, "uv at 69");
    chk(mdis, 1'b1, "uv disable");
    FM.dc_set = 8'h46;
    axi_wr(`DPS_OFS_CTRL, 32'hB);
    cyc(3);
    chk(uv_flt, 1'b0, "uv at 70");
    axi_wr(`DPS_OFS_CTRL, 32'h7);
    FM.dc_set = 8'h3C;
    cyc(3);
    chk(rt, 1'b1, "ride-through entry");
    chk(uv_flt, 1'b0, "uv during ride-through");
    FM.dc_set = 8'h64;
    axi_wr(`DPS_OFS_CTRL, 32'hB);
    $display("test undervoltage done");
  endtask

  task automatic t_ovs;
    FM.speed_set = 16'h07BC;
    cyc(100);
    chk(ovs_flt, 1'b0, "overspeed at limit");
    FM.speed_set = 16'h07BD;
    cyc(75);
    chk(ovs_flt, 1'b0, "overspeed too early");
    cyc(15);
    chk(ovs_flt, 1'b1, "overspeed missing");
    chk(mdis, 1'b1, "overspeed disable");
    FM.speed_set = 16'h03E8;
    axi_wr(`DPS_OFS_OVSMAR, 32'h64);
    axi_wr(`DPS_OFS_CTRL, 32'hB);
    FM.speed_set = 16'hFFFF;
    cyc(100);
    chk(ovs_flt, 1'b0, "margin 100 not off");
    FM.speed_set = 16'h03E8;
    $display("test overspeed done");
  endtask

  task automatic t_ext;
    axi_wr(`DPS_OFS_EXTSEL, 32'h0705);
    FM.di_set[4] = 1'b0;
    cyc(6);
    chk(ext_alm, 1'b1, "ext alarm on fall");
    chk(mdis, 1'b0, "ext alarm stops motor");
    FM.di_set[4] = 1'b1;
    cyc(6);
    chk(ext_alm, 1'b0, "ext alarm on rise");
    FM.di_set[6] = 1'b0;
    cyc(6);
    chk(ext_flt, 1'b1, "ext fault on fall");
    axi_wr(`DPS_OFS_CTRL, 32'hB);
    cyc(6);
    chk(ext_flt, 1'b0, "held low refires");
    FM.di_set[6] = 1'b1;
    cyc(6);
    $display("test external done");
  endtask

  task automatic t_auto;
    axi_wr(`DPS_OFS_ARTIME, 32'h3);
    FM.di_set[6] = 1'b0;
    cyc(7600);
    chk(ext_flt, 1'b1, "auto reset early");
    cyc(4800);
    chk(ext_flt, 1'b0, "auto reset missing");
    chk(mdis, 1'b0, "disable after auto");
    // Quick repeats after each auto reset; the third one inhibits
    for (int n = 0; n < 3; n++) begin
      FM.di_set[6] = 1'b1;
      cyc(6);
      FM.di_set[6] = 1'b0;
      cyc(6);
      chk(gdis, n == 2, "general disable count");
      cyc(12400);
      chk(ext_flt, n == 2, "auto reset after repeat");
    end
    axi_wr(`DPS_OFS_CTRL, 32'hB);
    cyc(3);
    chk(gdis, 1'b0, "inhibit not cleared");
    axi_wr(`DPS_OFS_ARTIME, 32'h2);
    FM.di_set[6] = 1'b1;
    cyc(6);
    FM.di_set[6] = 1'b0;
    cyc(12400);
    chk(ext_flt, 1'b1, "auto reset at 2 s");
    $display("test auto reset done");
  endtask

  // ====================
  // Sequence and verdict
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_reset;
    t_therm;
    t_uv;
    t_ovs;
    t_ext;
    t_auto;
    final_report;
  end
endmodule
